// ===== rtl/i2cs_pkg.sv
// Package: register map, field positions and types of the two-wire slave block
package i2cs_pkg;

    // ------------------------------------------------------------------
    // Register indices; byte address is four times the index
    // ------------------------------------------------------------------
    localparam logic [5:0] IDX_SLAVE_COMMAND_REG = 6'h0A;
    localparam logic [5:0] IDX_SLAVE_FLAGS       = 6'h0B;
    localparam logic [5:0] IDX_OWN_MATCH_ADDRESS = 6'h0C;
    localparam logic [5:0] IDX_SLAVE_SHIFT_DATA  = 6'h0D;
    localparam logic [5:0] IDX_SLAVE_CONTROL     = 6'h10;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CMD_LSB         = 0;
    localparam int ACK_CHOICE_BIT  = 2;
    localparam int FLG_DATA        = 7;
    localparam int FLG_MATCH_STOP  = 6;
    localparam int FLG_CONFLICT    = 3;
    localparam int FLG_BUS_FAULT   = 2;
    localparam int CTL_SLAVE_EN    = 0;
    localparam int CTL_STOP_FLAG   = 1;
    localparam int CTL_MASTER_EN   = 2;
    localparam int ADDR_GC_BIT     = 0;

    // ------------------------------------------------------------------
    // Reset values and counts
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_SLAVE_FLAGS       = 8'h00;
    localparam logic [7:0] RST_OWN_MATCH_ADDRESS = 8'h00;
    localparam logic [7:0] RST_SLAVE_CONTROL     = 8'h00;
    localparam logic [7:0] RST_SHIFT_DATA        = 8'h00;
    localparam logic [3:0] BITS_PER_BYTE         = 4'h8;
    localparam logic [6:0] GENERAL_CALL_ADDR     = 7'h00;

    typedef enum logic [1:0] {
        no_action_cmd            = 2'h0,
        reserved_cmd             = 2'h1,
        complete_transaction_cmd = 2'h2,
        response_cmd             = 2'h3
    } i2cs_cmd_t;

    typedef enum {
        ST_IDLE, ST_ADDR, ST_ADDR_HOLD, ST_ACK_OUT, ST_RX, ST_TX, ST_GET_ACK,
        ST_DATA_HOLD, ST_WAIT_START
    } i2cs_state_t;

    // Status register image, bit 7 down to bit 0
    typedef struct packed {
        logic slave_data_flag;
        logic match_or_stop_flag;
        logic scl_stretch_flag;
        logic received_ack_bit;
        logic drive_conflict_flag;
        logic bus_fault_flag;
        logic direction;
        logic match_stop_cause;
    } i2cs_status_t;

endpackage : i2cs_pkg

// ===== rtl/i2cs_slave.sv
// Two-wire slave command and status logic with an APB register slave
module i2cs_slave (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        scl_i,
    output logic             scl_o,
    output logic             scl_oe,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe
);

    // ------------------------------------------------------------------
    // Pin synchronisers and bus condition detection
    // ------------------------------------------------------------------
    logic [1:0] scl_sync_r;
    logic [1:0] sda_sync_r;
    logic       scl_d_r;
    logic       sda_d_r;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_det;
    logic       stop_det;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            scl_sync_r <= 2'h3;
            sda_sync_r <= 2'h3;
            scl_d_r    <= 1'b1;
            sda_d_r    <= 1'b1;
        end else begin
            scl_sync_r <= {scl_sync_r[0], scl_i};
            sda_sync_r <= {sda_sync_r[0], sda_i};
            scl_d_r    <= scl_sync_r[1];
            sda_d_r    <= sda_sync_r[1];
        end
    end

    assign scl_rise  = scl_sync_r[1] & ~scl_d_r;
    assign scl_fall  = ~scl_sync_r[1] & scl_d_r;
    assign start_det = scl_sync_r[1] & scl_d_r & sda_d_r & ~sda_sync_r[1];
    assign stop_det  = scl_sync_r[1] & scl_d_r & ~sda_d_r & sda_sync_r[1];

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    logic [5:0] idx;
    logic       acc;
    logic       mapped;
    logic       wr_cmd;
    logic       wr_stat;
    logic       wr_addr;
    logic       wr_ctl;
    logic       data_acc;
    logic       wr_data;

    assign idx      = paddr[7:2];
    assign mapped   = (idx == i2cs_pkg::IDX_SLAVE_COMMAND_REG) |
                      (idx == i2cs_pkg::IDX_SLAVE_FLAGS) |
                      (idx == i2cs_pkg::IDX_OWN_MATCH_ADDRESS) |
                      (idx == i2cs_pkg::IDX_SLAVE_SHIFT_DATA) |
                      (idx == i2cs_pkg::IDX_SLAVE_CONTROL);
    assign acc      = psel & penable;
    assign pready   = 1'b1;
    assign pslverr  = acc & ~mapped;
    assign wr_cmd   = acc & pwrite & (idx == i2cs_pkg::IDX_SLAVE_COMMAND_REG);
    assign wr_stat  = acc & pwrite & (idx == i2cs_pkg::IDX_SLAVE_FLAGS);
    assign wr_addr  = acc & pwrite & (idx == i2cs_pkg::IDX_OWN_MATCH_ADDRESS);
    assign wr_ctl   = acc & pwrite & (idx == i2cs_pkg::IDX_SLAVE_CONTROL);
    assign data_acc = acc & (idx == i2cs_pkg::IDX_SLAVE_SHIFT_DATA);
    assign wr_data  = data_acc & pwrite;

    // ------------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------------
    logic       ack_choice_r;
    logic [7:0] own_match_address_r;
    logic [7:0] slave_control_r;
    logic       ack_eff;
    i2cs_pkg::i2cs_cmd_t slave_command;
    logic       cmd_go;

    // Same write may carry a new ack choice and a command
    assign ack_eff       = wr_cmd ? pwdata[i2cs_pkg::ACK_CHOICE_BIT] : ack_choice_r;
    assign slave_command = i2cs_pkg::i2cs_cmd_t'(pwdata[i2cs_pkg::CMD_LSB +: 2]);
    // Codes 0 and 1 start nothing
    assign cmd_go        = wr_cmd & slave_command[1];

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ack_choice_r        <= 1'b0;
            own_match_address_r <= i2cs_pkg::RST_OWN_MATCH_ADDRESS;
            slave_control_r     <= i2cs_pkg::RST_SLAVE_CONTROL;
        end else begin
            if (wr_cmd) begin
                ack_choice_r <= pwdata[i2cs_pkg::ACK_CHOICE_BIT];
            end
            if (wr_addr) begin
                own_match_address_r <= pwdata[7:0];
            end
            if (wr_ctl) begin
                slave_control_r <= {5'h00, pwdata[2:0]};
            end
        end
    end

    // ------------------------------------------------------------------
    // Slave bus engine
    // ------------------------------------------------------------------
    i2cs_pkg::i2cs_state_t state_r;
    i2cs_pkg::i2cs_state_t after_ack_r;
    logic [7:0] shift_r;
    logic [3:0] bitcnt_r;
    logic       ack_sel_r;
    logic       dir_r;
    logic       received_ack_bit_r;
    logic       dif_r;
    logic       match_or_stop_flag_r;
    logic       cause_r;
    logic       drive_conflict_flag_r;
    logic       bus_fault_flag_r;
    logic       hold_r;
    logic       slave_en;
    logic       stop_en;
    logic       mst_en;
    logic       holding;
    logic       go;
    logic       addr_match;
    logic       dif_set;
    logic       match_or_stop_flag_set;
    logic       drive_conflict_flag_set;
    logic       bus_fault_flag_set;
    logic       sw_clear;
    logic       mid_byte;

    assign slave_en = slave_control_r[i2cs_pkg::CTL_SLAVE_EN];
    assign stop_en  = slave_control_r[i2cs_pkg::CTL_STOP_FLAG];
    assign mst_en   = slave_control_r[i2cs_pkg::CTL_MASTER_EN];
    assign holding  = (state_r == i2cs_pkg::ST_ADDR_HOLD) | (state_r == i2cs_pkg::ST_DATA_HOLD);
    // A data register access continues the transfer like a response command
    assign go       = holding & (cmd_go | data_acc);
    // Valid command or data access clears the data, match/stop and stretch flags
    assign sw_clear = cmd_go | data_acc;
    assign addr_match = (shift_r[7:1] == own_match_address_r[7:1]) |
                        (own_match_address_r[i2cs_pkg::ADDR_GC_BIT] &
                         (shift_r[7:1] == i2cs_pkg::GENERAL_CALL_ADDR));
    assign mid_byte = ((state_r == i2cs_pkg::ST_ADDR) | (state_r == i2cs_pkg::ST_RX) |
                       (state_r == i2cs_pkg::ST_TX)) & (bitcnt_r != 4'h0);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_r     <= i2cs_pkg::ST_IDLE;
            after_ack_r <= i2cs_pkg::ST_WAIT_START;
            shift_r     <= i2cs_pkg::RST_SHIFT_DATA;
            bitcnt_r    <= 4'h0;
            ack_sel_r   <= 1'b0;
            dir_r       <= 1'b0;
            received_ack_bit_r     <= 1'b0;
        end else if (!slave_en) begin
            state_r  <= i2cs_pkg::ST_IDLE;
            bitcnt_r <= 4'h0;
        end else if (stop_det) begin
            state_r <= i2cs_pkg::ST_IDLE;
        end else if (start_det) begin
            state_r  <= i2cs_pkg::ST_ADDR;
            bitcnt_r <= 4'h0;
        end else begin
            if (wr_data && holding) begin
                shift_r <= pwdata[7:0];
            end
            case (state_r)
                i2cs_pkg::ST_ADDR: begin
                    if (scl_rise) begin
                        shift_r  <= {shift_r[6:0], sda_sync_r[1]};
                        bitcnt_r <= bitcnt_r + 4'h1;
                    end else if (scl_fall && bitcnt_r == i2cs_pkg::BITS_PER_BYTE) begin
                        bitcnt_r <= 4'h0;
                        if (addr_match) begin
                            dir_r   <= shift_r[0];
                            state_r <= i2cs_pkg::ST_ADDR_HOLD;
                        end else begin
                            state_r <= i2cs_pkg::ST_WAIT_START;
                        end
                    end
                end
                i2cs_pkg::ST_ADDR_HOLD, i2cs_pkg::ST_DATA_HOLD: begin
                    ack_sel_r <= ack_eff;
                    if (go && slave_command == i2cs_pkg::complete_transaction_cmd && !data_acc) begin
                        after_ack_r <= i2cs_pkg::ST_WAIT_START;
                        state_r     <= dir_r ? i2cs_pkg::ST_WAIT_START
                                             : i2cs_pkg::ST_ACK_OUT;
                    end else if (go && state_r == i2cs_pkg::ST_ADDR_HOLD) begin
                        state_r     <= i2cs_pkg::ST_ACK_OUT;
                        after_ack_r <= (dir_r && !ack_eff) ? i2cs_pkg::ST_DATA_HOLD
                                     : (dir_r ? i2cs_pkg::ST_WAIT_START : i2cs_pkg::ST_RX);
                    end else if (go) begin
                        after_ack_r <= i2cs_pkg::ST_RX;
                        state_r     <= dir_r ? i2cs_pkg::ST_TX : i2cs_pkg::ST_ACK_OUT;
                    end
                end
                i2cs_pkg::ST_ACK_OUT: begin
                    if (scl_fall) begin
                        state_r <= after_ack_r;
                    end
                end
                i2cs_pkg::ST_RX: begin
                    if (scl_rise) begin
                        shift_r  <= {shift_r[6:0], sda_sync_r[1]};
                        bitcnt_r <= bitcnt_r + 4'h1;
                    end else if (scl_fall && bitcnt_r == i2cs_pkg::BITS_PER_BYTE) begin
                        bitcnt_r <= 4'h0;
                        state_r  <= i2cs_pkg::ST_DATA_HOLD;
                    end
                end
                i2cs_pkg::ST_TX: begin
                    if (scl_fall) begin
                        shift_r  <= {shift_r[6:0], 1'b1};
                        bitcnt_r <= bitcnt_r + 4'h1;
                        if (bitcnt_r == i2cs_pkg::BITS_PER_BYTE - 4'h1) begin
                            bitcnt_r <= 4'h0;
                            state_r  <= i2cs_pkg::ST_GET_ACK;
                        end
                    end
                end
                i2cs_pkg::ST_GET_ACK: begin
                    if (scl_rise) begin
                        received_ack_bit_r <= sda_sync_r[1];
                    end else if (scl_fall) begin
                        state_r <= i2cs_pkg::ST_DATA_HOLD;
                    end
                end
                i2cs_pkg::ST_IDLE, i2cs_pkg::ST_WAIT_START: begin
                    bitcnt_r <= 4'h0;
                end
                default: begin
                    state_r <= i2cs_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Flag set events
    // ------------------------------------------------------------------
    logic hold_enter;

    assign match_or_stop_flag_set   = slave_en & ~stop_det & ~start_det & (state_r == i2cs_pkg::ST_ADDR) &
                        scl_fall & (bitcnt_r == i2cs_pkg::BITS_PER_BYTE) & addr_match;
    assign dif_set    = slave_en & ~stop_det & ~start_det & scl_fall &
                        (((state_r == i2cs_pkg::ST_RX) &
                          (bitcnt_r == i2cs_pkg::BITS_PER_BYTE)) |
                         (state_r == i2cs_pkg::ST_GET_ACK) |
                         ((state_r == i2cs_pkg::ST_ACK_OUT) &
                          (after_ack_r == i2cs_pkg::ST_DATA_HOLD)));
    assign hold_enter = match_or_stop_flag_set | dif_set;
    // Wanted to release SDA high but saw it low
    assign drive_conflict_flag_set   = scl_rise & ~sda_sync_r[1] & ~sda_oe &
                        (((state_r == i2cs_pkg::ST_TX) & shift_r[7]) |
                         ((state_r == i2cs_pkg::ST_ACK_OUT) & ack_sel_r));
    assign bus_fault_flag_set = mst_en & ((start_det & mid_byte) |
                        (stop_det & (mid_byte | ((state_r == i2cs_pkg::ST_ADDR) &
                                                 (bitcnt_r == 4'h0)))));

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            dif_r  <= i2cs_pkg::RST_SLAVE_FLAGS[i2cs_pkg::FLG_DATA];
            match_or_stop_flag_r <= i2cs_pkg::RST_SLAVE_FLAGS[i2cs_pkg::FLG_MATCH_STOP];
        end else begin
            if (dif_set) begin
                dif_r <= 1'b1;
            end else if (sw_clear || (wr_stat && pwdata[i2cs_pkg::FLG_DATA])) begin
                dif_r <= 1'b0;
            end
            if (match_or_stop_flag_set || (stop_det && stop_en && slave_en)) begin
                match_or_stop_flag_r <= 1'b1;
            end else if (sw_clear || (wr_stat && pwdata[i2cs_pkg::FLG_MATCH_STOP])) begin
                match_or_stop_flag_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cause_r <= 1'b0;
        end else if (match_or_stop_flag_set) begin
            cause_r <= 1'b1;
        end else if (stop_det && stop_en && slave_en) begin
            cause_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            drive_conflict_flag_r   <= i2cs_pkg::RST_SLAVE_FLAGS[i2cs_pkg::FLG_CONFLICT];
            bus_fault_flag_r <= i2cs_pkg::RST_SLAVE_FLAGS[i2cs_pkg::FLG_BUS_FAULT];
        end else begin
            if (drive_conflict_flag_set) begin
                drive_conflict_flag_r <= 1'b1;
            end else if (start_det || (wr_stat && pwdata[i2cs_pkg::FLG_CONFLICT])) begin
                drive_conflict_flag_r <= 1'b0;
            end
            if (bus_fault_flag_set) begin
                bus_fault_flag_r <= 1'b1;
            end else if (wr_stat && pwdata[i2cs_pkg::FLG_BUS_FAULT]) begin
                bus_fault_flag_r <= 1'b0;
            end
        end
    end

    // Stretch lasts until a valid command, data access, data or match/stop flag clear write, start, stop or slave disable
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            hold_r <= 1'b0;
        end else if (hold_enter) begin
            hold_r <= 1'b1;
        end else if (sw_clear || stop_det || start_det || !slave_en ||
                     (wr_stat && (pwdata[i2cs_pkg::FLG_DATA] ||
                                  pwdata[i2cs_pkg::FLG_MATCH_STOP]))) begin
            hold_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Pin drive and read data
    // ------------------------------------------------------------------
    i2cs_pkg::i2cs_status_t status;

    assign status = '{slave_data_flag:     dif_r,
                      match_or_stop_flag:  match_or_stop_flag_r,
                      scl_stretch_flag:    hold_r,
                      received_ack_bit:    received_ack_bit_r,
                      drive_conflict_flag: drive_conflict_flag_r,
                      bus_fault_flag:      bus_fault_flag_r,
                      direction:           dir_r,
                      match_stop_cause:    cause_r};

    assign scl_o  = 1'b0;
    assign sda_o  = 1'b0;
    assign scl_oe = hold_r;
    // After a collision the slave drives no low level on SDA
    assign sda_oe = ~drive_conflict_flag_r & (((state_r == i2cs_pkg::ST_ACK_OUT) & ~ack_sel_r) |
                               ((state_r == i2cs_pkg::ST_TX) & ~shift_r[7]));

    logic [31:0] prdata_r;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            prdata_r <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            case (idx)
                i2cs_pkg::IDX_SLAVE_COMMAND_REG: prdata_r <= {29'h0, ack_choice_r, 2'h0};
                i2cs_pkg::IDX_SLAVE_FLAGS:       prdata_r <= {24'h0, status};
                i2cs_pkg::IDX_OWN_MATCH_ADDRESS: prdata_r <= {24'h0, own_match_address_r};
                i2cs_pkg::IDX_SLAVE_SHIFT_DATA:  prdata_r <= {24'h0, shift_r};
                i2cs_pkg::IDX_SLAVE_CONTROL:     prdata_r <= {24'h0, slave_control_r};
                default:                         prdata_r <= 32'h0000_0000;
            endcase
        end
    end

    assign prdata = prdata_r;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_cmd_reads_zero: assert property (@(posedge clk_sys) disable iff (rst)
        acc && !pwrite && idx == i2cs_pkg::IDX_SLAVE_COMMAND_REG |-> prdata[1:0] == 2'h0)
        else $error("command field read back nonzero");

    a_reserved_no_effect: assert property (@(posedge clk_sys) disable iff (rst)
        wr_cmd && !slave_command[1] && holding && slave_en && !start_det && !stop_det
        |=> state_r == $past(state_r) && hold_r == $past(hold_r) &&
            dif_r == $past(dif_r) && match_or_stop_flag_r == $past(match_or_stop_flag_r))
        else $error("reserved or no-action command changed bus state");

    a_dif_write_one: assert property (@(posedge clk_sys) disable iff (rst)
        wr_stat && pwdata[7] && !dif_set |=> !dif_r)
        else $error("writing one did not clear data flag");

    a_dif_write_zero: assert property (@(posedge clk_sys) disable iff (rst)
        wr_stat && !pwdata[7] && dif_r && !sw_clear |=> dif_r)
        else $error("writing zero changed data flag");

    a_stretch_release: assert property (@(posedge clk_sys) disable iff (rst)
        go && !hold_enter && !stop_det |=> !scl_oe && !dif_r && !match_or_stop_flag_r)
        else $error("command did not release clock stretch");

    a_drive_conflict_flag_start_clr: assert property (@(posedge clk_sys) disable iff (rst)
        start_det && !drive_conflict_flag_set |=> !drive_conflict_flag_r)
        else $error("collision flag survived a start");

    a_stop_gated: assert property (@(posedge clk_sys) disable iff (rst)
        stop_det && !stop_en && !match_or_stop_flag_r |=> !match_or_stop_flag_r)
        else $error("stop set flag while stop flag disabled");

    a_stop_cause: assert property (@(posedge clk_sys) disable iff (rst)
        stop_det && stop_en && slave_en |=> match_or_stop_flag_r && !cause_r)
        else $error("stop did not flag with cause zero");

    a_fault_gated: assert property (@(posedge clk_sys) disable iff (rst)
        !mst_en && !bus_fault_flag_r |=> !bus_fault_flag_r)
        else $error("bus fault set while master disabled");

    a_drive_conflict_flag_no_drive: assert property (@(posedge clk_sys) disable iff (rst)
        drive_conflict_flag_r |-> !sda_oe)
        else $error("slave drove sda low after collision");

endmodule : i2cs_slave

// ===== testbench/i2cs_master_model.sv
// Two-wire bus master model on the far side of the slave
module i2cs_master_model (
    input  wire logic clk_sys,
    input  wire logic scl,
    input  wire logic sda,
    output logic      scl_m,
    output logic      sda_m
);
    timeunit 1ns;
    timeprecision 1ps;
    logic ack_seen;
    logic stalled;
    initial {scl_m, sda_m, stalled} = 3'b110;
    task automatic pulse(input logic b);
        int k = 0;
        sda_m <= b;
        repeat (4) @(posedge clk_sys);
        scl_m <= 1'b1;
        // A stretched SCL does not count toward the high phase
        for (int n = 0; n < 400 && k < 4; n++) @(posedge clk_sys) k += int'(scl === 1'b1);
        // A stretch that never ends is reported to the bench
        if (k < 4) stalled <= 1'b1;
        {ack_seen, scl_m} <= {sda, 1'b0};
        repeat (4) @(posedge clk_sys);
    endtask : pulse
    task automatic mark(input logic p);
        sda_m <= 1'b0;
        repeat (4) @(posedge clk_sys);
        scl_m <= p;
        repeat (4) @(posedge clk_sys);
        sda_m <= p;
        repeat (4) @(posedge clk_sys);
    endtask : mark
    task automatic send(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) pulse(b[i]);
    endtask : send
endmodule : i2cs_master_model

// ===== testbench/i2cs_slave_tb_top.sv
// Self-checking bench for the two-wire slave command and status block
module i2cs_slave_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [5:0] CMD = i2cs_pkg::IDX_SLAVE_COMMAND_REG;
    localparam logic [5:0] FLG = i2cs_pkg::IDX_SLAVE_FLAGS;
    logic        clk_sys, rst, psel, penable, pwrite, pready, pslverr, err;
    logic        scl_oe, sda_oe, scl_m, sda_m, scl_o, sda_o, scl_bus, sda_bus;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    int          n_mismatch, check_count;
    // Open-drain wires: high unless a side drives its low output value
    assign scl_bus = scl_m & ~(scl_oe & ~scl_o);
    assign sda_bus = sda_m & ~(sda_oe & ~sda_o);
    i2cs_slave i_i2cs_slave (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .scl_i(scl_bus), .scl_o(scl_o), .scl_oe(scl_oe),
        .sda_i(sda_bus), .sda_o(sda_o), .sda_oe(sda_oe));
    i2cs_master_model i_i2cs_master_model (.clk_sys(clk_sys), .scl(scl_bus),
        .sda(sda_bus), .scl_m(scl_m), .sda_m(sda_m));
    initial forever #2 clk_sys = ~clk_sys;
    task automatic stop_test;
        $display("Checks %0d, mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        n_mismatch += int'(got !== exp);
        if (got !== exp) $display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
    endtask : chk
    task automatic apb(input logic w, input logic [5:0] idx, input logic [7:0] d);
        int n = 0;
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, idx, 26'h0, d};
        @(posedge clk_sys) penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1 && ++n < 50);
        n_mismatch += int'(n == 50);
        if (n == 50) stop_test();
        {q, err} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
        @(posedge clk_sys);
    endtask : apb
    task automatic rd(input logic [5:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00);
        chk(q[7:0], exp);
    endtask : rd
    // Master reads one byte; the first bit may be forced low to provoke a conflict
    task automatic get_byte(input logic b7, input logic [7:0] exp);
        logic [7:0] got;
        for (int i = 7; i >= 0; i--) begin
            i_i2cs_master_model.pulse(i == 7 ? b7 : 1'b1);
            got[i] = i_i2cs_master_model.ack_seen;
        end
        chk(got, exp);
    endtask : get_byte
    initial begin
        {clk_sys, rst, psel, penable, pwrite, paddr, pwdata} = {2'b01, 43'h0};
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        rd(FLG, i2cs_pkg::RST_SLAVE_FLAGS);
        apb(1'b1, i2cs_pkg::IDX_OWN_MATCH_ADDRESS, 8'hA4);
        rd(i2cs_pkg::IDX_OWN_MATCH_ADDRESS, 8'hA4);
        rd(6'h0F, 8'h00);
        chk({7'h00, err}, 8'h01);
        apb(1'b1, i2cs_pkg::IDX_SLAVE_CONTROL, 8'h03);
        i_i2cs_master_model.mark(1'b0);
        i_i2cs_master_model.send(8'hA4);
        rd(FLG, 8'h61);
        chk({7'h00, scl_oe}, 8'h01);
        apb(1'b1, CMD, 8'h01);
        apb(1'b1, FLG, 8'h00);
        rd(FLG, 8'h61);
        apb(1'b1, CMD, 8'h03);
        rd(FLG, 8'h01);
        i_i2cs_master_model.pulse(1'b1);
        chk({7'h00, i_i2cs_master_model.ack_seen}, 8'h00);
        i_i2cs_master_model.send(8'h5A);
        rd(FLG, 8'hA1);
        apb(1'b1, CMD, 8'h06);
        rd(CMD, 8'h04);
        i_i2cs_master_model.pulse(1'b1);
        chk({7'h00, i_i2cs_master_model.ack_seen}, 8'h01);
        i_i2cs_master_model.mark(1'b1);
        rd(FLG, 8'h40);
        apb(1'b1, FLG, 8'h40);
        rd(FLG, 8'h00);
        apb(1'b1, i2cs_pkg::IDX_SLAVE_CONTROL, 8'h07);
        i_i2cs_master_model.mark(1'b0);
        i_i2cs_master_model.mark(1'b1);
        rd(FLG, 8'h44);
        apb(1'b1, FLG, 8'h44);
        i_i2cs_master_model.mark(1'b0);
        i_i2cs_master_model.send(8'hA5);
        rd(FLG, 8'h63);
        apb(1'b1, CMD, 8'h03);
        i_i2cs_master_model.pulse(1'b1);
        chk({7'h00, i_i2cs_master_model.ack_seen}, 8'h00);
        rd(FLG, 8'hA3);
        apb(1'b1, i2cs_pkg::IDX_SLAVE_SHIFT_DATA, 8'hC3);
        rd(FLG, 8'h03);
        get_byte(1'b1, 8'hC3);
        i_i2cs_master_model.pulse(1'b1);
        rd(FLG, 8'hB3);
        apb(1'b1, i2cs_pkg::IDX_SLAVE_SHIFT_DATA, 8'h80);
        get_byte(1'b0, 8'h7F);
        i_i2cs_master_model.pulse(1'b0);
        rd(FLG, 8'hAB);
        apb(1'b1, CMD, 8'h02);
        i_i2cs_master_model.mark(1'b1);
        i_i2cs_master_model.mark(1'b0);
        rd(FLG, 8'h42);
        chk({7'h00, i_i2cs_master_model.stalled}, 8'h00);
        chk({6'h00, scl_o, sda_o}, 8'h00);
        stop_test();
    end
endmodule : i2cs_slave_tb_top
